// >>> rtl/fault_signal_pkg.sv
// fault_signal_pkg: shared types and constants for the error node fault signaling gate.
// assumes a single clock domain; every control and status bit is a plain port of the top module.
package fault_signal_pkg;

    // how each fault interrupt enable or abort enable is built
    typedef enum logic [1:0] {
        CTRL_ABSENT,
        CTRL_SINGLE,
        CTRL_SPLIT
    } ctrl_impl_type;

    // classification of a recorded error
    typedef enum logic [1:0] {
        CLASS_NONE,
        CLASS_CORRECTED,
        CLASS_DEFERRED,
        CLASS_UNCORRECTED
    } err_class_type;

    localparam int SYNDROME_W = 8;

    // software fault syndrome codes
    localparam logic [SYNDROME_W-1:0] SYND_ILLEGAL_ADDRESS = 8'h0d;
    localparam logic [SYNDROME_W-1:0] SYND_ILLEGAL_ACCESS  = 8'h0e;
    localparam logic [SYNDROME_W-1:0] SYND_ILLEGAL_STATE   = 8'h0f;

    // software fault kinds, reported by the requester-side checker
    typedef enum logic [1:0] {
        SWF_NONE,
        SWF_ADDRESS,
        SWF_ACCESS,
        SWF_STATE
    } swf_kind_type;

    // control bits written by software
    typedef struct packed {
        logic corrected_event_irq_enable;
        logic general_fault_irq_enable;
        logic general_fault_irq_enable_rd;
        logic general_fault_irq_enable_wr;
        logic uncorrected_abort_enable;
        logic read_abort_enable;
        logic write_abort_enable;
    } node_control_reg_type;

    // feature bits read by software
    typedef struct packed {
        logic         fault_irq_present;
        logic         corrected_ctl_present;
        ctrl_impl_type general_ctl;
        logic         abort_present;
        ctrl_impl_type abort_ctl;
        logic         counter_present;
    } node_feature_reg_type;

    // one error as presented by the recording logic
    typedef struct packed {
        logic                  valid;
        err_class_type         err_class;
        logic                  is_write;
        logic                  syndrome_dropped;
        swf_kind_type          swf_kind;
        logic [SYNDROME_W-1:0] syndrome;
    } err_report_type;

    localparam logic RESET_LEVEL = 1'b0;

endpackage

// >>> rtl/abort_decider.sv
// abort_decider: decides whether an uncorrected error is answered with an in-band error response.
// assumes the control and report inputs are already on the core clock; purely combinational.
`timescale 1ns/1ps

module abort_decider #(
    parameter bit            ABORT_PRESENT = 1'b1,
    parameter fault_signal_pkg::ctrl_impl_type ABORT_CTL = fault_signal_pkg::CTRL_SINGLE
) (
    input  wire logic                                  uncorrected_i,
    input  wire logic                                  is_write_i,
    input  wire fault_signal_pkg::node_control_reg_type ctrl_i,
    output logic                                       abort_o
);
    import fault_signal_pkg::*;

    logic enabled;

    always_comb
    begin
        // absent support means no enable and no abort
        if (!ABORT_PRESENT)
        begin
            enabled = 1'b0;
        end
        else
        begin
            unique case (ABORT_CTL)
                CTRL_ABSENT:
                    enabled = 1'b1;
                CTRL_SINGLE:
                    enabled = ctrl_i.uncorrected_abort_enable;
                CTRL_SPLIT:
                    enabled = is_write_i ? ctrl_i.write_abort_enable : ctrl_i.read_abort_enable;
                default:
                    enabled = 1'b0;
            endcase
        end
        abort_o = enabled & uncorrected_i;
    end

endmodule

// >>> rtl/error_node_fault_signaling.sv
// error_node_fault_signaling: per-node gate for the fault handling interrupt and in-band aborts.
// assumes error reports, counter overflows and software writes arrive on CORE_CLK_I; no register bus.
//
// What this block does
// - feature output tells software which fault and abort enables exist.
// - corrected-event interrupt enable is optional when fault interrupt exists.
// - with that enable, corrected events interrupt only while it is one.
// - with corrected enable, general enable gates deferred and uncorrected errors.
// - without corrected enable, a general enable may still exist.
// - general enable alone gates all three error classes together.
// - without general enable, every deferred or uncorrected error and every corrected event raises the fault interrupt.
// - no fault interrupt means neither enable is implemented.
// - with a counter, overflow setting the flag from zero is an event.
// - software set or repeated overflow may or may not give an event.
// - without a counter, each corrected recording is a corrected event.
// - general interrupt enable is single or split into read and write; corrected enable is single.
// - interrupt is raised even when the syndrome is dropped.
// - abort enable is optional when in-band responses are supported.
// - with abort enable, uncorrected errors abort only while it is one.
// - support without enable means uncorrected errors always abort.
// - no abort support means no abort enable is implemented.
// - abort enable is single or split into read and write.
// - an uncorrected error answered with abort sets the status abort flag.
// - software faults record syndrome codes 13, 14 and 15.
`timescale 1ns/1ps

module error_node_fault_signaling #(
    parameter bit                              FAULT_IRQ_PRESENT     = 1'b1,
    parameter bit                              CORRECTED_CTL_PRESENT = 1'b1,
    parameter fault_signal_pkg::ctrl_impl_type GENERAL_CTL           = fault_signal_pkg::CTRL_SINGLE,
    parameter bit                              ABORT_PRESENT         = 1'b1,
    parameter fault_signal_pkg::ctrl_impl_type ABORT_CTL             = fault_signal_pkg::CTRL_SINGLE,
    parameter bit                              COUNTER_PRESENT       = 1'b1,
    parameter bit                              EVENT_ON_SW_SET       = 1'b0
) (
    input  wire logic                                   CORE_CLK_I,
    input  wire logic                                   RST_I,
    input  wire fault_signal_pkg::node_control_reg_type NODE_CONTROL_REG_I,
    input  wire fault_signal_pkg::err_report_type       ERR_REPORT_I,
    input  wire logic                                   COUNTER_OVERFLOW_I,
    input  wire logic                                   OVERFLOW_SW_SET_I,
    input  wire logic                                   OVERFLOW_SW_CLEAR_I,
    input  wire logic                                   VALID_CLEAR_I,
    output logic                                        FAULT_IRQ_O,
    output logic                                        ABORT_RESP_O,
    output logic                                        RECORD_VALID_O,
    output logic                                        INBAND_ABORT_FLAG_O,
    output logic                                        OVERFLOW_FLAG_O,
    output logic [fault_signal_pkg::SYNDROME_W-1:0]     SYNDROME_CLASS_CODE_O,
    output fault_signal_pkg::err_class_type             RECORD_CLASS_O,
    output fault_signal_pkg::node_feature_reg_type      NODE_FEATURE_REG_O
);
    import fault_signal_pkg::*;

    typedef struct packed {
        logic                  irq;
        logic                  abort_resp;
        logic                  valid;
        logic                  inband_abort_flag;
        logic                  overflow_flag;
        logic [SYNDROME_W-1:0] syndrome_class_code;
        err_class_type         rec_class;
        node_feature_reg_type  feature;
    } state_type;

    state_type state;
    state_type next_state;

    // enables exist only with a fault interrupt
    localparam bit CORR_CTL_IMPL = FAULT_IRQ_PRESENT && CORRECTED_CTL_PRESENT;
    localparam ctrl_impl_type GEN_CTL_IMPL = !FAULT_IRQ_PRESENT ? CTRL_ABSENT :
                                             (CORR_CTL_IMPL && GENERAL_CTL == CTRL_ABSENT) ? CTRL_SINGLE :
                                             GENERAL_CTL;

    logic                 rec;
    logic                 is_corr;
    logic                 corr_event;
    logic                 general_en;
    logic                 corr_en;
    logic                 qualifies;
    logic                 abort_now;
    logic                 ctrl_uncorrected;
    node_control_reg_type ctrl;

    function automatic logic [SYNDROME_W-1:0] swf_code(input swf_kind_type kind,
                                                       input logic [SYNDROME_W-1:0] other);
        unique case (kind)
            SWF_ADDRESS: swf_code = SYND_ILLEGAL_ADDRESS;
            SWF_ACCESS:  swf_code = SYND_ILLEGAL_ACCESS;
            SWF_STATE:   swf_code = SYND_ILLEGAL_STATE;
            SWF_NONE:    swf_code = other;
        endcase
    endfunction

    assign ctrl             = NODE_CONTROL_REG_I;
    assign ctrl_uncorrected = ERR_REPORT_I.valid && ERR_REPORT_I.err_class == CLASS_UNCORRECTED;

    abort_decider #(
        .ABORT_PRESENT (ABORT_PRESENT),
        .ABORT_CTL     (ABORT_CTL)
    ) u_abort (
        .uncorrected_i (ctrl_uncorrected),
        .is_write_i    (ERR_REPORT_I.is_write),
        .ctrl_i        (ctrl),
        .abort_o       (abort_now)
    );

    always_comb
    begin
        next_state = state;
        rec     = ERR_REPORT_I.valid && ERR_REPORT_I.err_class != CLASS_NONE;
        is_corr = rec && ERR_REPORT_I.err_class == CLASS_CORRECTED;

        unique case (GEN_CTL_IMPL)
            // absent general enable means enabled whenever the fault interrupt exists
            CTRL_ABSENT: general_en = FAULT_IRQ_PRESENT;
            CTRL_SINGLE: general_en = ctrl.general_fault_irq_enable;
            CTRL_SPLIT:  general_en = ERR_REPORT_I.is_write ? ctrl.general_fault_irq_enable_wr
                                                            : ctrl.general_fault_irq_enable_rd;
            default:     general_en = 1'b0;
        endcase

        // corrected events follow their own enable, or the general one when theirs is absent
        corr_en = CORR_CTL_IMPL ? ctrl.corrected_event_irq_enable : general_en;

        // overflow raising the flag from zero
        // repeat or software set is a build choice
        // without a counter, corrected records are events
        if (COUNTER_PRESENT)
        begin
            corr_event = (COUNTER_OVERFLOW_I && (!state.overflow_flag || EVENT_ON_SW_SET))
                       || (EVENT_ON_SW_SET && OVERFLOW_SW_SET_I && !state.overflow_flag);
        end
        else
        begin
            corr_event = is_corr;
        end

        // general enable gates deferred and uncorrected
        qualifies = FAULT_IRQ_PRESENT
                  && ((corr_event && corr_en) || (rec && !is_corr && general_en));

        // overflow flag: set wins over software clear
        if (OVERFLOW_SW_CLEAR_I)
        begin
            next_state.overflow_flag = 1'b0;
        end
        if (COUNTER_PRESENT && (COUNTER_OVERFLOW_I || OVERFLOW_SW_SET_I))
        begin
            next_state.overflow_flag = 1'b1;
        end

        // record status; a clear in the same cycle as a new record loses
        if (VALID_CLEAR_I)
        begin
            next_state.valid             = 1'b0;
            next_state.inband_abort_flag = 1'b0;
            next_state.irq               = 1'b0;
        end
        if (rec)
        begin
            next_state.valid = 1'b1;
            // dropped syndromes keep the higher priority one already held
            if (!ERR_REPORT_I.syndrome_dropped || !state.valid || VALID_CLEAR_I)
            begin
                next_state.rec_class = ERR_REPORT_I.err_class;
                next_state.syndrome_class_code = swf_code(ERR_REPORT_I.swf_kind, ERR_REPORT_I.syndrome);
            end
            if (abort_now)
            begin
                next_state.inband_abort_flag = 1'b1;
            end
        end

        // level interrupt held until valid clears
        if (qualifies)
        begin
            next_state.irq = 1'b1;
        end

        // response to the requester one cycle after the report
        next_state.abort_resp = abort_now;

        next_state.feature.fault_irq_present     = FAULT_IRQ_PRESENT;
        next_state.feature.corrected_ctl_present = CORR_CTL_IMPL;
        next_state.feature.general_ctl           = GEN_CTL_IMPL;
        next_state.feature.abort_present         = ABORT_PRESENT;
        next_state.feature.abort_ctl             = ABORT_PRESENT ? ABORT_CTL : CTRL_ABSENT;
        next_state.feature.counter_present       = COUNTER_PRESENT;
    end

    always_ff @(posedge CORE_CLK_I)
    begin
        if (RST_I)
        begin
            state <= '0;
        end
        else
        begin
            state <= next_state;
        end
    end

    // feature output shows zero during reset and the build value from the next edge on
    assign FAULT_IRQ_O           = state.irq;
    assign ABORT_RESP_O          = state.abort_resp;
    assign RECORD_VALID_O        = state.valid;
    assign INBAND_ABORT_FLAG_O   = state.inband_abort_flag;
    assign OVERFLOW_FLAG_O       = state.overflow_flag;
    assign SYNDROME_CLASS_CODE_O = state.syndrome_class_code;
    assign RECORD_CLASS_O        = state.rec_class;
    assign NODE_FEATURE_REG_O    = state.feature;

endmodule

// >>> testbench/fabric_model.sv
// fabric_model: far side of the gate, the interrupt fabric and the requester.
// assumes the core clock and reset of the fault gate.
`timescale 1ns/1ps

module fabric_model (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic irq_i,
    input  wire logic abort_i,
    output int        irq_rises_o,
    output int        aborts_o
);
    logic irq_last;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            irq_last    <= 1'b0;
            irq_rises_o <= 0;
            aborts_o    <= 0;
        end
        else
        begin
            irq_last <= irq_i;
            // level interrupt, so only a rise counts
            if (irq_i && !irq_last)
                irq_rises_o <= irq_rises_o + 1;
            // one error response per pulse
            if (abort_i)
                aborts_o <= aborts_o + 1;
        end
    end
endmodule

// >>> testbench/error_node_fault_signaling_monitor.sv
// error_node_fault_signaling_monitor: port assertions for the fault gate.
// assumes the default build: single enables, counter present.
`timescale 1ns/1ps

module error_node_fault_signaling_monitor (
    input wire logic                                   CORE_CLK_I,
    input wire logic                                   RST_I,
    input wire fault_signal_pkg::node_control_reg_type NODE_CONTROL_REG_I,
    input wire fault_signal_pkg::err_report_type       ERR_REPORT_I,
    input wire logic                                   COUNTER_OVERFLOW_I,
    input wire logic                                   OVERFLOW_SW_SET_I,
    input wire logic                                   VALID_CLEAR_I,
    input wire logic                                   FAULT_IRQ_O,
    input wire logic                                   ABORT_RESP_O,
    input wire logic                                   RECORD_VALID_O,
    input wire logic                                   INBAND_ABORT_FLAG_O,
    input wire logic                                   OVERFLOW_FLAG_O
);
    import fault_signal_pkg::*;
    default clocking @(posedge CORE_CLK_I); endclocking
    default disable iff (RST_I);

    sequence s_uncorr;
        ERR_REPORT_I.valid && ERR_REPORT_I.err_class == CLASS_UNCORRECTED;
    endsequence
    // nothing this cycle could set the record or the interrupt
    sequence s_quiet;
        !ERR_REPORT_I.valid && !COUNTER_OVERFLOW_I && !OVERFLOW_SW_SET_I;
    endsequence

    property p_abort_on;
        s_uncorr ##0 NODE_CONTROL_REG_I.uncorrected_abort_enable |=> ABORT_RESP_O && INBAND_ABORT_FLAG_O;
    endproperty
    a_abort_on: assert property (p_abort_on) else $error("abort missing");
    property p_abort_off;
        s_uncorr ##0 !NODE_CONTROL_REG_I.uncorrected_abort_enable |=> !ABORT_RESP_O;
    endproperty
    a_abort_off: assert property (p_abort_off) else $error("abort while disabled");
    property p_abort_cause;
        ABORT_RESP_O |-> $past(ERR_REPORT_I.valid && ERR_REPORT_I.err_class == CLASS_UNCORRECTED);
    endproperty
    a_abort_cause: assert property (p_abort_cause) else $error("abort without cause");
    property p_flag_rise;
        $rose(INBAND_ABORT_FLAG_O) |-> ABORT_RESP_O && RECORD_VALID_O;
    endproperty
    a_flag_rise: assert property (p_flag_rise) else $error("abort flag without abort");
    property p_irq_general;
        ERR_REPORT_I.valid && ERR_REPORT_I.err_class inside {CLASS_DEFERRED, CLASS_UNCORRECTED}
            && NODE_CONTROL_REG_I.general_fault_irq_enable |=> FAULT_IRQ_O;
    endproperty
    a_irq_general: assert property (p_irq_general) else $error("irq missing");
    property p_irq_masked;
        !FAULT_IRQ_O && !COUNTER_OVERFLOW_I && !NODE_CONTROL_REG_I.general_fault_irq_enable
            && ERR_REPORT_I.valid && ERR_REPORT_I.err_class == CLASS_DEFERRED |=> !FAULT_IRQ_O;
    endproperty
    a_irq_masked: assert property (p_irq_masked) else $error("irq while masked");
    property p_corr_event;
        COUNTER_OVERFLOW_I && !OVERFLOW_FLAG_O && NODE_CONTROL_REG_I.corrected_event_irq_enable
            |=> OVERFLOW_FLAG_O && FAULT_IRQ_O;
    endproperty
    a_corr_event: assert property (p_corr_event) else $error("corrected event lost");
    property p_corr_masked;
        COUNTER_OVERFLOW_I && !ERR_REPORT_I.valid && !FAULT_IRQ_O
            && !NODE_CONTROL_REG_I.corrected_event_irq_enable |=> !FAULT_IRQ_O;
    endproperty
    a_corr_masked: assert property (p_corr_masked) else $error("corrected irq masked");
    property p_irq_holds;
        FAULT_IRQ_O && !VALID_CLEAR_I |=> FAULT_IRQ_O;
    endproperty
    a_irq_holds: assert property (p_irq_holds) else $error("irq dropped early");
    property p_irq_clear;
        VALID_CLEAR_I ##0 s_quiet |=> !FAULT_IRQ_O && !RECORD_VALID_O && !INBAND_ABORT_FLAG_O;
    endproperty
    a_irq_clear: assert property (p_irq_clear) else $error("record not cleared");
endmodule

bind error_node_fault_signaling error_node_fault_signaling_monitor u_monitor (
    .CORE_CLK_I(CORE_CLK_I), .RST_I(RST_I), .NODE_CONTROL_REG_I(NODE_CONTROL_REG_I),
    .ERR_REPORT_I(ERR_REPORT_I), .COUNTER_OVERFLOW_I(COUNTER_OVERFLOW_I),
    .OVERFLOW_SW_SET_I(OVERFLOW_SW_SET_I), .VALID_CLEAR_I(VALID_CLEAR_I), .FAULT_IRQ_O(FAULT_IRQ_O),
    .ABORT_RESP_O(ABORT_RESP_O), .RECORD_VALID_O(RECORD_VALID_O),
    .INBAND_ABORT_FLAG_O(INBAND_ABORT_FLAG_O), .OVERFLOW_FLAG_O(OVERFLOW_FLAG_O));

// >>> testbench/testbench.sv
// testbench: directed scenarios for the fault gate, default build parameters.
// assumes package, design, partner model and monitor are compiled first.
`timescale 1ns/1ps

module testbench;
    import fault_signal_pkg::*;
    logic                  clk;
    logic                  rst;
    node_control_reg_type  ctrl;
    err_report_type        rep;
    logic                  ovf, sw_set, sw_clr, vclr, irq, abort, rvalid, aflag, oflag;
    logic [SYNDROME_W-1:0] synd;
    err_class_type         cls;
    node_feature_reg_type  feat;
    int                    irq_rises, aborts;
    int                    fails = 0;
    int                    num_checks = 0;
    wire logic [7:0]       st = {3'h0, irq, abort, rvalid, aflag, oflag};

    error_node_fault_signaling u_dut (.CORE_CLK_I(clk), .RST_I(rst), .NODE_CONTROL_REG_I(ctrl),
        .ERR_REPORT_I(rep), .COUNTER_OVERFLOW_I(ovf), .OVERFLOW_SW_SET_I(sw_set), .OVERFLOW_SW_CLEAR_I(sw_clr),
        .VALID_CLEAR_I(vclr), .FAULT_IRQ_O(irq), .ABORT_RESP_O(abort), .RECORD_VALID_O(rvalid),
        .INBAND_ABORT_FLAG_O(aflag), .OVERFLOW_FLAG_O(oflag), .SYNDROME_CLASS_CODE_O(synd),
        .RECORD_CLASS_O(cls), .NODE_FEATURE_REG_O(feat));
    fabric_model u_fabric (.clk_i(clk), .rst_i(rst), .irq_i(irq), .abort_i(abort),
        .irq_rises_o(irq_rises), .aborts_o(aborts));

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("unexpected %s: expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic report(input err_class_type c, input logic drop, input swf_kind_type k);
        @(posedge clk);
        rep <= '{1'b1, c, 1'b0, drop, k, 8'h00};
        @(posedge clk);
        rep.valid <= 1'b0;
        #1;
    endtask

    // pulses overflow, software set, flag clear and valid clear together
    task automatic strobe(input logic [3:0] v);
        @(posedge clk);
        {ovf, sw_set, sw_clr, vclr} <= v;
        @(posedge clk);
        {ovf, sw_set, sw_clr, vclr} <= 4'h0;
        #1;
    endtask

    task automatic set_ctrl(input logic [6:0] v);
        @(posedge clk);
        ctrl <= v;
    endtask

    task automatic t_uncorr();
        set_ctrl(7'h24);
        report(CLASS_UNCORRECTED, 1'b0, SWF_NONE);
        chk("status", 8'h1e, st);
        @(posedge clk);
        #1;
        chk("status", 8'h16, st);
        strobe(4'h1);
        chk("status", 8'h00, st);
        chk("aborts", 8'h01, 8'(aborts));
        chk("irq rises", 8'h01, 8'(irq_rises));
        $display("test uncorrected done");
    endtask

    // deferred record while masked, then a dropped uncorrected one
    task automatic t_masked_dropped();
        set_ctrl(7'h00);
        report(CLASS_DEFERRED, 1'b0, SWF_NONE);
        chk("status", 8'h04, st);
        set_ctrl(7'h20);
        report(CLASS_UNCORRECTED, 1'b1, SWF_NONE);
        chk("status", 8'h14, st);
        chk("class", 8'h02, {6'h0, cls});
        strobe(4'h1);
        $display("test masked and dropped done");
    endtask

    task automatic t_corrected();
        set_ctrl(7'h40);
        strobe(4'h8);
        chk("status", 8'h11, st);
        strobe(4'h3);
        chk("status", 8'h00, st);
        set_ctrl(7'h00);
        strobe(4'h8);
        chk("status", 8'h01, st);
        set_ctrl(7'h40);
        strobe(4'h2);
        report(CLASS_CORRECTED, 1'b0, SWF_NONE);
        chk("status", 8'h04, st);
        strobe(4'h1);
        strobe(4'h4);
        chk("flag", 8'h01, {7'h0, oflag});
        strobe(4'h8);
        chk("status", 8'h01, st & 8'h0f);
        strobe(4'h2);
        $display("test corrected done");
    endtask

    task automatic t_swf();
        for (int k = 1; k < 4; k++)
        begin
            report(CLASS_UNCORRECTED, 1'b0, swf_kind_type'(k));
            chk("syndrome", 8'(8'h0c + k), synd);
            chk("status", 8'h04, st);
            strobe(4'h1);
        end
        chk("irq rises", 8'h03, 8'(irq_rises));
        $display("test software faults done");
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    initial
    begin
        rst = 1'b1;
        ctrl = '0;
        rep = '0;
        {ovf, sw_set, sw_clr, vclr} = 4'h0;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1;
        chk("feature", 8'hdb, feat);
        t_uncorr();
        t_masked_dropped();
        t_corrected();
        t_swf();
        end_of_test();
    end

    // a hang counts as a mismatch
    initial
    begin
        repeat (2000) @(posedge clk);
        fails++;
        end_of_test();
    end
endmodule
